//--- rtl/pfc_meter_scaling_regs.v
// Scaling, averaging and fast overcurrent register bank of the metering PFC controller
`include "pfc_meter_defs.vh"

// Notes on behaviour
// - Exponent register: current [10:6], voltage [5:3], power [2:0]; 15:11 reserved.
// - Rms readings average over half line cycles chosen by update rate bits [2:0].
// - Window codes give 0,16,64,128,512,1024,4096,8192 half line cycles.
// - Voltage scale: mantissa [9:0], signed exponent [13:11]; 15,14,10 reserved.
// - Sense gain: mantissa [9:0], signed exponent [15:11]; bit 10 reserved.
// - Overcurrent declared only after sense stays above limit for debounce time.
// - After debounce trip, all PWM outputs held off until cycle ends.
// - Debounce codes: 00 is 40 ns, 01 is 80 ns, 10 is 120 ns.
module pfc_meter_scaling_regs (
    input  wire        clk,
    input  wire        rst_b,
    input  wire [15:0] regAddr,
    input  wire [15:0] regWrData,
    input  wire        regWr,
    input  wire        regRd,
    input  wire        halfCycleTick,
    input  wire        aboveLimitPin,
    input  wire        cycleStart,
    output reg  [15:0] regRdData_r,
    output reg  [4:0]  currentExponent_r,
    output reg  [2:0]  voltageExponent_r,
    output reg  [2:0]  powerExponent_r,
    output reg  [9:0]  voltageScaleMant_r,
    output reg  [2:0]  voltageScaleExp_r,
    output reg  [9:0]  senseGainMant_r,
    output reg  [4:0]  senseGainExp_r,
    output reg  [13:0] avgWindowLen_r,
    output reg         avgWindowEnd_r,
    output wire        overcurrentEvent,
    output wire        pwmForceOff
);
    reg  [15:0] readingExponents_r;
    reg  [15:0] updateRate_r;
    reg  [15:0] voltageScale_r;
    reg  [15:0] senseGain_r;
    reg  [15:0] ocBlanking_r;
    reg  [13:0] halfCycleCnt_r;
    reg  [13:0] windowLen;
    reg  [15:0] rdMux;
    wire [13:0] cntNext;

    // Masks keep reserved bits at zero on every write
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            readingExponents_r <= `RST_READING_EXPONENTS;
            updateRate_r       <= `RST_READING_UPDATE_RATE;
            voltageScale_r     <= `RST_INPUT_VOLTAGE_SCALE;
            senseGain_r        <= `RST_CURRENT_SENSE_GAIN;
            ocBlanking_r       <= `RST_FAST_OC_BLANKING;
        end else if (regWr) begin
            case (regAddr)
                `ADDR_READING_EXPONENTS:
                    readingExponents_r <= regWrData & `MASK_READING_EXPONENTS;
                `ADDR_READING_UPDATE_RATE:
                    updateRate_r <= regWrData & `MASK_READING_UPDATE_RATE;
                `ADDR_INPUT_VOLTAGE_SCALE:
                    voltageScale_r <= regWrData & `MASK_INPUT_VOLTAGE_SCALE;
                `ADDR_CURRENT_SENSE_GAIN:
                    senseGain_r <= regWrData & `MASK_CURRENT_SENSE_GAIN;
                `ADDR_FAST_OC_BLANKING:
                    ocBlanking_r <= regWrData & `MASK_FAST_OC_BLANKING;
                default: ;
            endcase
        end
    end

    always @* begin
        case (regAddr)
            `ADDR_READING_EXPONENTS:   rdMux = readingExponents_r;
            `ADDR_READING_UPDATE_RATE: rdMux = updateRate_r;
            `ADDR_INPUT_VOLTAGE_SCALE: rdMux = voltageScale_r;
            `ADDR_CURRENT_SENSE_GAIN:  rdMux = senseGain_r;
            `ADDR_FAST_OC_BLANKING:    rdMux = ocBlanking_r;
            default:                   rdMux = 16'h0000;
        endcase
    end

    always @* begin
        case (updateRate_r[`AVG_WIN_HI:`AVG_WIN_LO])
            3'h0:    windowLen = `AVG_HC_0;
            3'h1:    windowLen = `AVG_HC_1;
            3'h2:    windowLen = `AVG_HC_2;
            3'h3:    windowLen = `AVG_HC_3;
            3'h4:    windowLen = `AVG_HC_4;
            3'h5:    windowLen = `AVG_HC_5;
            3'h6:    windowLen = `AVG_HC_6;
            default: windowLen = `AVG_HC_7;
        endcase
    end

    assign cntNext = halfCycleCnt_r + 14'h0001;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData_r        <= 16'h0000;
            currentExponent_r  <= 5'h00;
            voltageExponent_r  <= 3'h0;
            powerExponent_r    <= 3'h0;
            voltageScaleMant_r <= 10'h000;
            voltageScaleExp_r  <= 3'h0;
            senseGainMant_r    <= 10'h000;
            senseGainExp_r     <= 5'h00;
            avgWindowLen_r     <= 14'h0000;
            avgWindowEnd_r     <= 1'b0;
            halfCycleCnt_r     <= 14'h0000;
        end else begin
            if (regRd) begin
                regRdData_r <= rdMux;
            end
            currentExponent_r  <= readingExponents_r[`CUR_EXP_HI:`CUR_EXP_LO];
            voltageExponent_r  <= readingExponents_r[`VOLT_EXP_HI:`VOLT_EXP_LO];
            powerExponent_r    <= readingExponents_r[`PWR_EXP_HI:`PWR_EXP_LO];
            voltageScaleMant_r <= voltageScale_r[`MANT_HI:`MANT_LO];
            voltageScaleExp_r  <= voltageScale_r[`VSCALE_EXP_HI:`SCALE_EXP_LO];
            senseGainMant_r    <= senseGain_r[`MANT_HI:`MANT_LO];
            senseGainExp_r     <= senseGain_r[`GAIN_EXP_HI:`SCALE_EXP_LO];
            avgWindowLen_r     <= windowLen;
            // A zero window closes on every half cycle, i.e. no averaging
            avgWindowEnd_r     <= 1'b0;
            if (halfCycleTick) begin
                if (cntNext >= windowLen) begin
                    halfCycleCnt_r <= 14'h0000;
                    avgWindowEnd_r <= 1'b1;
                end else begin
                    halfCycleCnt_r <= cntNext;
                end
            end
        end
    end

    overcurrent_debounce ocDebounce (
        .clk                (clk),
        .rst_b              (rst_b),
        .aboveLimitPin      (aboveLimitPin),
        .cycleStart         (cycleStart),
        .debounceSel        (ocBlanking_r[`OC_DB_HI:`OC_DB_LO]),
        .overcurrentEvent_r (overcurrentEvent),
        .pwmForceOff_r      (pwmForceOff)
    );
endmodule

//--- shared/pfc_meter_defs.vh
// Register map, field layout, reset values and timing counts of the scaling bank
`ifndef PFC_METER_DEFS_VH
`define PFC_METER_DEFS_VH

`define ADDR_READING_EXPONENTS   16'hFE39
`define ADDR_READING_UPDATE_RATE 16'hFE3A
`define ADDR_INPUT_VOLTAGE_SCALE 16'hFE3B
`define ADDR_CURRENT_SENSE_GAIN  16'hFE3C
`define ADDR_FAST_OC_BLANKING    16'hFE3D

`define MASK_READING_EXPONENTS   16'h07FF
`define MASK_READING_UPDATE_RATE 16'h0007
`define MASK_INPUT_VOLTAGE_SCALE 16'h3BFF
`define MASK_CURRENT_SENSE_GAIN  16'hFBFF
`define MASK_FAST_OC_BLANKING    16'h0018

`define RST_READING_EXPONENTS    16'h0000
`define RST_READING_UPDATE_RATE  16'h0000
`define RST_INPUT_VOLTAGE_SCALE  16'h0000
`define RST_CURRENT_SENSE_GAIN   16'h0000
`define RST_FAST_OC_BLANKING     16'h0000

`define CUR_EXP_HI   10
`define CUR_EXP_LO   6
`define VOLT_EXP_HI  5
`define VOLT_EXP_LO  3
`define PWR_EXP_HI   2
`define PWR_EXP_LO   0
`define AVG_WIN_HI   2
`define AVG_WIN_LO   0
`define MANT_HI      9
`define MANT_LO      0
`define VSCALE_EXP_HI 13
`define GAIN_EXP_HI  15
`define SCALE_EXP_LO 11
`define OC_DB_HI     4
`define OC_DB_LO     3

`define CLK_PERIOD_NS 40
`define OC_DB0_NS     40
`define OC_DB1_NS     80
`define OC_DB2_NS     120
`define OC_DB0_CYC    ((`OC_DB0_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OC_DB1_CYC    ((`OC_DB1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OC_DB2_CYC    ((`OC_DB2_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define AVG_HC_0 14'h0000
`define AVG_HC_1 14'h0010
`define AVG_HC_2 14'h0040
`define AVG_HC_3 14'h0080
`define AVG_HC_4 14'h0200
`define AVG_HC_5 14'h0400
`define AVG_HC_6 14'h1000
`define AVG_HC_7 14'h2000

`endif

//--- rtl/overcurrent_debounce.v
// Fast overcurrent debounce and per-cycle PWM shutdown
`include "pfc_meter_defs.vh"

module overcurrent_debounce (
    input  wire       clk,
    input  wire       rst_b,
    input  wire       aboveLimitPin,
    input  wire       cycleStart,
    input  wire [1:0] debounceSel,
    output reg        overcurrentEvent_r,
    output reg        pwmForceOff_r
);
    reg       sync1_r;
    reg       sync2_r;
    reg       sync3_r;
    reg       above_r;
    reg [1:0] cnt_r;
    reg [1:0] need;
    wire      trip;

    // Whole-cycle counts; only the low two bits are ever needed
    localparam [31:0] DB0_CYC = `OC_DB0_CYC;
    localparam [31:0] DB1_CYC = `OC_DB1_CYC;
    localparam [31:0] DB2_CYC = `OC_DB2_CYC;

    // Code 11 is undefined here; held at the longest setting
    always @* begin
        case (debounceSel)
            2'h0:    need = DB0_CYC[1:0];
            2'h1:    need = DB1_CYC[1:0];
            default: need = DB2_CYC[1:0];
        endcase
    end

    // Fires once per excursion, only after an unbroken run above the limit
    assign trip = above_r && (cnt_r == need - 2'h1);

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r            <= 1'b0;
            sync2_r            <= 1'b0;
            sync3_r            <= 1'b0;
            above_r            <= 1'b0;
            cnt_r              <= 2'h0;
            overcurrentEvent_r <= 1'b0;
            pwmForceOff_r      <= 1'b0;
        end else begin
            sync1_r <= aboveLimitPin;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            // Level accepted only when the last two stages agree
            if (sync2_r == sync3_r) begin
                above_r <= sync3_r;
            end
            if (!above_r) begin
                cnt_r <= 2'h0;
            end else if (cnt_r != 2'h3) begin
                cnt_r <= cnt_r + 2'h1;
            end
            overcurrentEvent_r <= trip;
            // Set wins over the cycle boundary so a late trip is not lost
            if (trip) begin
                pwmForceOff_r <= 1'b1;
            end else if (cycleStart) begin
                pwmForceOff_r <= 1'b0;
            end
        end
    end
endmodule

//--- testbench/host_model.sv
// Host model driving the register command port
module host_model (
    input  wire logic   clk,
    output logic [15:0] regAddr,
    output logic [15:0] regWrData,
    output logic        regWr,
    output logic        regRd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {regAddr, regWrData, regWr, regRd} = '0;
    // Released bus shows inverted values, not the last ones
    task xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= w;
        regRd <= !w;
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask
endmodule

//--- testbench/pfc_meter_scaling_regs_sva.sv
// Port assertions for the scaling register bank
module pfc_meter_scaling_regs_sva (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic        halfCycleTick,
    input wire logic        cycleStart,
    input wire logic [15:0] regRdData_r,
    input wire logic [2:0]  voltageScaleExp_r,
    input wire logic [4:0]  senseGainExp_r,
    input wire logic [13:0] avgWindowLen_r,
    input wire logic        avgWindowEnd_r,
    input wire logic        overcurrentEvent,
    input wire logic        pwmForceOff
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] wd1_r;
    logic [15:0] wd2_r;
    // Write data two edges back, when field outputs settle
    always @(posedge clk) begin
        wd1_r <= regWrData;
        wd2_r <= wd1_r;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence sWr(a); regWr && regAddr == a; endsequence
    AST_RD_UNMAPPED: assert property (
        regRd && regAddr > 16'hFE3D |=> regRdData_r == 16'h0000) else $error("unmapped read");
    AST_VSCALE_EXP: assert property (
        sWr(16'hFE3B) |=> ##1 voltageScaleExp_r == wd2_r[13:11]) else $error("scale exponent");
    AST_GAIN_EXP: assert property (
        sWr(16'hFE3C) |=> ##1 senseGainExp_r == wd2_r[15:11]) else $error("gain exponent");
    AST_WIN_LEN: assert property (
        regWr && regAddr == 16'hFE3A && regWrData[2:0] == 3'h6 |=> ##1
        avgWindowLen_r == 14'h1000) else $error("window length");
    AST_WIN_END: assert property (
        avgWindowEnd_r |-> $past(halfCycleTick)) else $error("window end without tick");
    AST_OC_PULSE: assert property (
        overcurrentEvent |=> !overcurrentEvent) else $error("trip not a pulse");
    AST_OC_FORCE: assert property (
        $rose(pwmForceOff) |-> overcurrentEvent) else $error("shutdown without trip");
    AST_OC_HOLD: assert property (
        pwmForceOff && !cycleStart |=> pwmForceOff) else $error("shutdown dropped early");
    AST_OC_SET_WINS: assert property (
        overcurrentEvent |-> pwmForceOff) else $error("trip without shutdown");
endmodule
bind pfc_meter_scaling_regs pfc_meter_scaling_regs_sva pfc_meter_scaling_regs_sva_i (
    .clk, .rst_b, .regAddr, .regWrData, .regWr, .regRd, .halfCycleTick, .cycleStart,
    .regRdData_r, .voltageScaleExp_r, .senseGainExp_r, .avgWindowLen_r, .avgWindowEnd_r,
    .overcurrentEvent, .pwmForceOff);

//--- testbench/pfc_meter_scaling_regs_test.sv
// Self-checking bench for the scaling register bank
module pfc_meter_scaling_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic halfCycleTick = 1'b0;
    logic aboveLimitPin = 1'b0;
    logic cycleStart = 1'b0;
    logic rdSeen = 1'b0;
    logic regWr, regRd, avgWindowEnd_r, overcurrentEvent, pwmForceOff;
    logic [15:0] regAddr, regWrData, regRdData_r, d, e;
    logic [4:0]  currentExponent_r, senseGainExp_r;
    logic [2:0]  voltageExponent_r, powerExponent_r, voltageScaleExp_r;
    logic [9:0]  voltageScaleMant_r, senseGainMant_r;
    logic [13:0] avgWindowLen_r;
    logic [15:0] expQ[$];
    logic [15:0] masks[5] = '{16'h07FF, 16'h0007, 16'h3BFF, 16'hFBFF, 16'h0018};
    logic [13:0] lens[8] = '{14'h0000, 14'h0010, 14'h0040, 14'h0080, 14'h0200,
        14'h0400, 14'h1000, 14'h2000};
    int fail_count = 0;
    int check_count = 0;
    int endCnt = 0;
    int ocCnt = 0;
    always #20 clk = ~clk;
    host_model host_model_i (.clk, .regAddr, .regWrData, .regWr, .regRd);
    pfc_meter_scaling_regs pfc_meter_scaling_regs_i (.clk, .rst_b, .regAddr, .regWrData,
        .regWr, .regRd, .halfCycleTick, .aboveLimitPin, .cycleStart, .regRdData_r,
        .currentExponent_r, .voltageExponent_r, .powerExponent_r,
        .voltageScaleMant_r, .voltageScaleExp_r, .senseGainMant_r, .senseGainExp_r,
        .avgWindowLen_r, .avgWindowEnd_r, .overcurrentEvent, .pwmForceOff);
    task check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        if (fail_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task wr(input logic [15:0] a, input logic [15:0] v);
        host_model_i.xfer(1'b1, a, v);
    endtask
    task rd(input logic [15:0] a, input logic [15:0] e);
        expQ.push_back(e);
        host_model_i.xfer(1'b0, a, 16'h0000);
    endtask
    // Read data lands one edge after the strobe
    always @(posedge clk) rdSeen <= regRd;
    always @(negedge clk) begin
        if (rdSeen) check(regRdData_r, expQ.pop_front());
        if (avgWindowEnd_r) endCnt++;
        if (overcurrentEvent) ocCnt++;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h3C8DC27E));
        cyc(4);
        rst_b <= 1'b1;
        for (int k = 0; k < 20; k++) begin
            d = 16'($urandom());
            e = (k < 5) ? 16'h0000 : d & masks[k % 5];
            if (k >= 5) wr(16'hFE39 + 16'(k % 5), d);
            rd(16'hFE39 + 16'(k % 5), e);
            // Field outputs settled one edge after the write, one edge before here
            case (k % 5)
                0: begin
                    check(16'(currentExponent_r), 16'(e[10:6]));
                    check(16'(voltageExponent_r), 16'(e[5:3]));
                    check(16'(powerExponent_r), 16'(e[2:0]));
                end
                2: begin
                    check(16'(voltageScaleMant_r), 16'(e[9:0]));
                    check(16'(voltageScaleExp_r), 16'(e[13:11]));
                end
                3: begin
                    check(16'(senseGainMant_r), 16'(e[9:0]));
                    check(16'(senseGainExp_r), 16'(e[15:11]));
                end
                default: ;
            endcase
        end
        wr(16'hFE3E, 16'hFFFF);
        rd(16'hFE3E, 16'h0000);
        rd(16'hFE38, 16'h0000);
        for (int c = 0; c < 8; c++) begin
            wr(16'hFE3A, 16'(c));
            cyc(3);
            check(16'(avgWindowLen_r), 16'(lens[c]));
        end
        for (int c = 1; c >= 0; c--) begin
            wr(16'hFE3A, 16'(c));
            cyc(2);
            endCnt = 0;
            for (int t = 0; t < 16; t++) begin
                halfCycleTick <= 1'b1;
                cyc(1);
                halfCycleTick <= 1'b0;
                cyc(2);
                if (t == 14) check(16'(endCnt), 16'(15 * (1 - c)));
            end
            check(16'(endCnt), 16'(16 - 15 * c));
        end
        for (int c = 0; c < 3; c++) begin
            wr(16'hFE3D, 16'(c << 3));
            ocCnt = 0;
            aboveLimitPin <= 1'b1;
            cyc(1);
            aboveLimitPin <= 1'b0;
            cyc(8);
            aboveLimitPin <= 1'b1;
            // Four edges of filtering, then the debounce count; a shorter count shows here
            cyc(5 + c);
            check(16'(ocCnt), 16'h0000);
            cyc(1);
            check(16'(ocCnt), 16'h0001);
            check(16'(pwmForceOff), 16'h0001);
            aboveLimitPin <= 1'b0;
            cyc(8);
            cycleStart <= 1'b1;
            cyc(1);
            cycleStart <= 1'b0;
            cyc(2);
            check(16'(pwmForceOff), 16'h0000);
        end
        report_and_stop();
    end
endmodule
